/* File: src/scan_seq_regs.vh */
`ifndef SCAN_SEQ_REGS_VH
`define SCAN_SEQ_REGS_VH

// Register offsets (byte-wide register index on the command port)
`define CONV_CFG_ADDR 8'h08
`define CELL_EN_ADDR 8'h09
`define ACQ_CFG_ADDR 8'h0C
`define CONV_CTRL_ADDR 8'h0D
`define CELL_DATA_BASE 8'h20
`define CELL_DATA_LAST 8'h2B
`define AUX_ONE_ADDR 8'h2C
`define AUX_TWO_ADDR 8'h2D
`define DIAG_RES_ADDR 8'h2E

// Field positions
`define CTRL_SCAN_BIT 0
`define CTRL_BUSY_BIT 1
`define CFG_AUX_ONE_EN_BIT 0
`define CFG_AUX_TWO_EN_BIT 1
`define CFG_DIAG_EN_BIT 2

// Reset values
`define CONV_CFG_RST 16'h0000
`define CELL_EN_RST 16'h0000
`define ACQ_CFG_RST 16'h0000

// Timing in nanoseconds and clock period
`define CLK_PERIOD_NS 10
`define SETUP_TIME_NS 11300
`define FIRST_SAMPLE_NS 5670
`define NEXT_SAMPLE_NS 3830
`define SETTLE_UNIT_NS 1000

// Cycle counts, least times rounded up
`define SETUP_CYC ((`SETUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIRST_SAMPLE_CYC ((`FIRST_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NEXT_SAMPLE_CYC ((`NEXT_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_UNIT_CYC ((`SETTLE_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Converter channel codes
`define CHAN_DIAG 4'hD
`define CHAN_AUX_ONE 4'hE
`define CHAN_AUX_TWO 4'hF

`endif

/* File: src/interval_timer.v */
`timescale 1ns/10ps
// Down counter; done pulses LOAD_VAL cycles after the load pulse
module interval_timer #(
  parameter W = 24
) (
  input wire clk_sys,
  input wire rstn,
  input wire load,
  input wire [W-1:0] load_val,
  output reg done
);
  reg [W-1:0] count_reg; // Cycles left

  // Count down to zero, flag the last step
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      count_reg <= {W{1'b0}};
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (load)
        count_reg <= load_val;
      else if (count_reg != {W{1'b0}})
      begin
        count_reg <= count_reg - {{(W-1){1'b0}}, 1'b1};
        // Last cycle of the interval
        if (count_reg == {{(W-1){1'b0}}, 1'b1})
          done <= 1'b1;
      end
    end
  end
endmodule // interval_timer

/* File: src/cell_scan_sequencer.v */
`timescale 1ns/10ps
`include "scan_seq_regs.vh"
// Function
// R1: Scan only cells enabled in cell enables
// R2: Aux and diagnostic gated by configuration bits
// R3: Scan starts on conversion trigger bit write
// R4: Trigger while busy is ignored entirely
// R5: Order cells p1, cells p2, diag, aux
// R6: Average both phases, then write cell data
// R7: Diagnostic two phases back to back
// R8: Each aux converted once, own result
// R9: Extra settling before each enabled aux
// R10: Setup interval before first cell sample
// R11: First cell sampled longer than others
// R12: Start scan immediately on trigger
// R13: Forward trigger within one microsecond
// R14: Host reads results by broadcast read
// R15: Broadcast read frame layout on bus
// R16: Host trigger write is five bytes
// R17: Only enabled cells' data registers update
// R18: Busy held until last result stored
module cell_scan_sequencer #(
  parameter OFFSET_TRIM = 12'h000,
  parameter SETTLE_UNIT = 16'd100
) (
  input wire clk_sys,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_bcast,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  output reg trig_fwd,
  output reg adc_start,
  output reg [3:0] adc_chan,
  output reg adc_chop,
  input wire adc_done,
  input wire [11:0] adc_data,
  output reg busy
);
  // Sequencer states, one-hot
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_SETUP = 5'h02;
  localparam [4:0] S_SETTLE = 5'h04;
  localparam [4:0] S_SAMPLE = 5'h08;
  localparam [4:0] S_CONV = 5'h10;
  // Scan stages
  localparam [2:0] ST_PRE = 3'h0;
  localparam [2:0] ST_CELL1 = 3'h1;
  localparam [2:0] ST_CELL2 = 3'h2;
  localparam [2:0] ST_DIAG1 = 3'h3;
  localparam [2:0] ST_DIAG2 = 3'h4;
  localparam [2:0] ST_AUX1 = 3'h5;
  localparam [2:0] ST_AUX2 = 3'h6;
  localparam [2:0] ST_DONE = 3'h7;
  // Interval counts at timer width
  localparam [23:0] SETUP_CYC = `SETUP_CYC;
  localparam [23:0] FIRST_CYC = `FIRST_SAMPLE_CYC;
  localparam [23:0] NEXT_CYC = `NEXT_SAMPLE_CYC;
  reg [15:0] conv_cfg_reg; // Converter configuration
  reg [15:0] cell_en_reg; // Cell input enables
  reg [15:0] acq_cfg_reg; // Acquisition settling configuration
  reg [11:0] cell_data [0:11]; // Corrected cell results
  reg [11:0] raw1 [0:11]; // Phase one readings
  reg [11:0] raw2 [0:11]; // Phase two readings
  reg [11:0] aux_one_reg; // First auxiliary result
  reg [11:0] aux_two_reg; // Second auxiliary result
  reg [11:0] diag_p1_reg; // Diagnostic phase one reading
  reg [11:0] diag_res_reg; // Diagnostic corrected result
  reg [4:0] state_reg; // Sequencer state
  reg [2:0] stage_reg; // Current scan stage
  reg [3:0] cell_reg; // Current cell index, cell number minus one
  reg [11:0] mask_reg; // Cells enabled at trigger
  reg diag_en_reg; // Diagnostic enabled at trigger
  reg aux1_en_reg; // First aux enabled at trigger
  reg aux2_en_reg; // Second aux enabled at trigger
  reg [7:0] settle_reg; // Settle units latched at trigger
  reg [2:0] stage_next; // Stage after the current one
  reg [3:0] cell_next; // Cell after the current one
  reg tmr_load; // Timer load pulse
  reg [23:0] tmr_val; // Timer load value
  wire tmr_done; // Interval elapsed
  wire [2:0] after_cells; // Stage that follows the cell phases
  wire [2:0] after_diag; // Stage that follows the diagnostic
  wire accept; // Trigger taken
  wire [4:0] top_cell; // Highest enabled cell
  wire [4:0] below_cell; // Next enabled cell below current
  wire [23:0] settle_cyc; // Extra settling length
  integer k;
  // Highest enabled index below lim; bit 4 set when none
  function [4:0] find_below;
    input [11:0] m;
    input [4:0] lim;
    integer i;
    reg [4:0] r;
    begin
      r = 5'h1F;
      for (i = 0; i < 12; i = i + 1)
        if (m[i] && (i < lim))
          r = i[4:0];
      find_below = r;
    end
  endfunction
  // Chopped average with offset trim, saturating at zero
  function [11:0] avg_corr;
    input [11:0] a;
    input [11:0] b;
    reg [12:0] s;
    begin
      s = {1'b0, a} + {1'b0, b} + 13'h0001;
      avg_corr = (s[12:1] > OFFSET_TRIM) ? s[12:1] - OFFSET_TRIM : 12'h000;
    end
  endfunction
  // Trigger taken only while idle
  assign accept = reg_wr && (reg_addr == `CONV_CTRL_ADDR) && reg_wdata[`CTRL_SCAN_BIT] && !busy; // see R3, R4
  assign top_cell = find_below(mask_reg, 5'd12);
  assign below_cell = find_below(mask_reg, {1'b0, cell_reg});
  assign after_diag = aux1_en_reg ? ST_AUX1 : (aux2_en_reg ? ST_AUX2 : ST_DONE);
  assign after_cells = diag_en_reg ? ST_DIAG1 : after_diag; // see R2
  assign settle_cyc = {16'h0000, settle_reg} * {8'h00, SETTLE_UNIT[15:0]};
  interval_timer #(
    .W(24)
  ) u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );
  // Next item of the scan in the fixed order
  always @*
  begin
    stage_next = ST_DONE;
    cell_next = cell_reg;
    case (stage_reg)
      ST_PRE:
      begin
        stage_next = after_cells; // see R2
        if (!top_cell[4])
        begin
          stage_next = ST_CELL1; // see R1
          cell_next = top_cell[3:0];
        end
      end
      ST_CELL1:
      begin
        stage_next = below_cell[4] ? ST_CELL2 : ST_CELL1; // see R5
        cell_next = below_cell[4] ? top_cell[3:0] : below_cell[3:0];
      end
      ST_CELL2:
      begin
        stage_next = below_cell[4] ? after_cells : ST_CELL2; // see R5
        cell_next = below_cell[4] ? cell_reg : below_cell[3:0];
      end
      ST_DIAG1:
        stage_next = ST_DIAG2; // see R7
      ST_DIAG2:
        stage_next = after_diag;
      ST_AUX1:
        stage_next = aux2_en_reg ? ST_AUX2 : ST_DONE;
      default:
        stage_next = ST_DONE;
    endcase
  end
  // Interval to run before the next item; settling end reloads the sample default
  always @*
  begin
    tmr_load = 1'b0;
    tmr_val = NEXT_CYC;
    if (accept)
    begin
      tmr_load = 1'b1;
      tmr_val = SETUP_CYC; // see R10
    end
    else if (((state_reg == S_SETUP && tmr_done) || (state_reg == S_CONV && adc_done)) && stage_next != ST_DONE)
    begin
      tmr_load = 1'b1;
      if ((stage_next == ST_AUX1 || stage_next == ST_AUX2) && settle_reg != 8'h00)
        tmr_val = settle_cyc; // see R9
      else if ((stage_next == ST_CELL1 || stage_next == ST_CELL2) && stage_next != stage_reg)
        tmr_val = FIRST_CYC; // see R11
    end
    else if (state_reg == S_SETTLE && tmr_done)
      tmr_load = 1'b1;
  end
  // Register writes from the command port
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_cfg_reg <= `CONV_CFG_RST;
      cell_en_reg <= `CELL_EN_RST;
      acq_cfg_reg <= `ACQ_CFG_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CONV_CFG_ADDR: conv_cfg_reg <= reg_wdata;
        `CELL_EN_ADDR: cell_en_reg <= reg_wdata;
        `ACQ_CFG_ADDR: acq_cfg_reg <= reg_wdata;
        default: ;
      endcase
    end
  end
  // Register read mux, answer one cycle after the strobe
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      // Cell results sit in the default arm, one word is two data bytes
      case (reg_addr)
        `CONV_CFG_ADDR: reg_rdata <= conv_cfg_reg;
        `CELL_EN_ADDR: reg_rdata <= cell_en_reg;
        `ACQ_CFG_ADDR: reg_rdata <= acq_cfg_reg;
        `CONV_CTRL_ADDR: reg_rdata <= {14'h0000, busy, 1'b0};
        `AUX_ONE_ADDR: reg_rdata <= {aux_one_reg, 4'h0};
        `AUX_TWO_ADDR: reg_rdata <= {aux_two_reg, 4'h0};
        `DIAG_RES_ADDR: reg_rdata <= {diag_res_reg, 4'h0};
        default: reg_rdata <= (reg_addr >= `CELL_DATA_BASE && reg_addr <= `CELL_DATA_LAST) ?
          {cell_data[reg_addr[3:0]], 4'h0} : 16'h0000; // see R14, R15
      endcase
    end
  end
  // Scan sequencer and converter handshake
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= S_IDLE;
      stage_reg <= ST_PRE;
      cell_reg <= 4'h0;
      mask_reg <= 12'h000;
      diag_en_reg <= 1'b0;
      aux1_en_reg <= 1'b0;
      aux2_en_reg <= 1'b0;
      settle_reg <= 8'h00;
      busy <= 1'b0;
      trig_fwd <= 1'b0;
      adc_start <= 1'b0;
      adc_chan <= 4'h0;
      adc_chop <= 1'b0;
      aux_one_reg <= 12'h000;
      aux_two_reg <= 12'h000;
      diag_p1_reg <= 12'h000;
      diag_res_reg <= 12'h000;
      for (k = 0; k < 12; k = k + 1)
      begin
        cell_data[k] <= 12'h000;
        raw1[k] <= 12'h000;
        raw2[k] <= 12'h000;
      end
    end
    else
    begin
      adc_start <= 1'b0;
      trig_fwd <= accept && reg_bcast; // see R13
      case (state_reg)
        S_IDLE:
        begin
          if (accept)
          begin
            // Start at once and snapshot the scan setup
            state_reg <= S_SETUP; // see R12
            busy <= 1'b1; // see R18
            stage_reg <= ST_PRE;
            mask_reg <= cell_en_reg[11:0];
            diag_en_reg <= conv_cfg_reg[`CFG_DIAG_EN_BIT];
            aux1_en_reg <= conv_cfg_reg[`CFG_AUX_ONE_EN_BIT];
            aux2_en_reg <= conv_cfg_reg[`CFG_AUX_TWO_EN_BIT];
            settle_reg <= acq_cfg_reg[7:0];
          end
        end
        S_SETUP, S_CONV:
        begin
          if ((state_reg == S_SETUP && tmr_done) || (state_reg == S_CONV && adc_done))
          begin
            // Store the finished reading
            if (state_reg == S_CONV)
            begin
              case (stage_reg)
                ST_CELL1: raw1[cell_reg] <= adc_data;
                ST_CELL2: raw2[cell_reg] <= adc_data;
                ST_DIAG1: diag_p1_reg <= adc_data;
                ST_DIAG2: diag_res_reg <= avg_corr(diag_p1_reg, adc_data);
                ST_AUX1: aux_one_reg <= adc_data; // see R8
                ST_AUX2: aux_two_reg <= adc_data; // see R8
                default: ;
              endcase
            end
            // Both phases done: publish enabled cells only
            if (stage_reg == ST_CELL2 && stage_next != ST_CELL2)
              for (k = 0; k < 12; k = k + 1)
                if (mask_reg[k])
                  cell_data[k] <= avg_corr(raw1[k], (k == cell_reg) ? adc_data : raw2[k]); // see R6, R17
            stage_reg <= stage_next;
            cell_reg <= cell_next;
            if (stage_next == ST_DONE)
            begin
              state_reg <= S_IDLE;
              stage_reg <= ST_PRE;
              busy <= 1'b0; // see R18
            end
            else if ((stage_next == ST_AUX1 || stage_next == ST_AUX2) && settle_reg != 8'h00)
              state_reg <= S_SETTLE;
            else
              state_reg <= S_SAMPLE;
          end
        end
        S_SETTLE:
        begin
          if (tmr_done)
            state_reg <= S_SAMPLE;
        end
        S_SAMPLE:
        begin
          if (tmr_done)
          begin
            // Sampling over, launch the conversion
            state_reg <= S_CONV;
            adc_start <= 1'b1;
            adc_chop <= (stage_reg == ST_CELL2) || (stage_reg == ST_DIAG2);
            case (stage_reg)
              ST_DIAG1, ST_DIAG2: adc_chan <= `CHAN_DIAG;
              ST_AUX1: adc_chan <= `CHAN_AUX_ONE;
              ST_AUX2: adc_chan <= `CHAN_AUX_TWO;
              default: adc_chan <= cell_reg + 4'h1;
            endcase
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // cell_scan_sequencer

/* File: verification/scan_seq_checker.sv */
`timescale 1ns/10ps
`include "scan_seq_regs.vh"
// Watches scan start, pacing and handshakes at the sequencer ports
module scan_seq_checker #(
  parameter OFFSET_TRIM = 12'h000,
  parameter SETTLE_UNIT = 16'd100
) (
  input wire clk_sys,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire reg_bcast,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  input wire trig_fwd,
  input wire adc_start,
  input wire [3:0] adc_chan,
  input wire adc_chop,
  input wire adc_done,
  input wire [11:0] adc_data,
  input wire busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Trigger write that the idle sequencer must accept
  sequence trig_seq;
    reg_wr && reg_addr == `CONV_CTRL_ADDR && reg_wdata[`CTRL_SCAN_BIT] && !busy;
  endsequence
  // No conversion may start in the eight cycles after a trigger or a result
  sequence quiet_seq;
    !adc_start [*8];
  endsequence
  trig_busy_a: assert property (trig_seq |=> busy) else $error("trigger not taken");
  busy_cause_a: assert property ($rose(busy) |-> $past(reg_wr) && $past(reg_addr) == `CONV_CTRL_ADDR)
    else $error("busy without trigger");
  fwd_match_a: assert property (trig_seq |=> trig_fwd == $past(reg_bcast)) else $error("forward wrong");
  fwd_pulse_a: assert property (trig_fwd |-> $rose(busy) ##1 !trig_fwd) else $error("stray forward");
  setup_quiet_a: assert property (trig_seq |=> quiet_seq) else $error("no setup time");
  done_quiet_a: assert property (adc_done |=> quiet_seq) else $error("no sample time");
  start_busy_a: assert property (adc_start |-> busy ##1 !adc_start) else $error("start outside scan");
  chan_hold_a: assert property (!adc_start |-> $stable(adc_chan) && $stable(adc_chop))
    else $error("channel moved");
  aux_single_a: assert property (adc_start && adc_chan >= `CHAN_AUX_ONE |-> !adc_chop)
    else $error("aux chopped");
  busy_end_a: assert property ($fell(busy) |-> $past(adc_done)) else $error("busy end wrong");
endmodule // scan_seq_checker

bind cell_scan_sequencer scan_seq_checker #(.OFFSET_TRIM(OFFSET_TRIM), .SETTLE_UNIT(SETTLE_UNIT)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bcast(reg_bcast), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .trig_fwd(trig_fwd), .adc_start(adc_start), .adc_chan(adc_chan),
  .adc_chop(adc_chop), .adc_done(adc_done), .adc_data(adc_data), .busy(busy));

/* File: verification/adc_model.sv */
`timescale 1ns/10ps
// Converter stand-in: answers each start after 1 or 9 cycles
module adc_model (
  input wire clk_sys,
  input wire rstn,
  input wire slow,
  input wire adc_start,
  input wire [3:0] adc_chan,
  input wire adc_chop,
  output reg adc_done,
  output reg [11:0] adc_data
);
  // Cycles left in the conversion, 0 when idle
  reg [3:0] left;
  // Result: channel code high, base 0x40 or 0x50 when slow, phase two two counts above
  reg [11:0] res;
  // Data is valid only with done; otherwise it toggles so nothing stale passes
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      left <= 4'h0;
      res <= 12'h000;
      adc_done <= 1'b0;
      adc_data <= 12'h000;
    end
    else
    begin
      adc_done <= (left == 4'h1);
      adc_data <= (left == 4'h1) ? res : ~adc_data;
      if (adc_start)
      begin
        left <= slow ? 4'h9 : 4'h1;
        res <= {adc_chan, (slow ? 8'h50 : 8'h40)} + {10'h000, adc_chop, 1'b0};
      end
      else if (left != 4'h0)
        left <= left - 4'h1;
    end
  end
endmodule // adc_model

/* File: verification/tb.sv */
`timescale 1ns/10ps
`include "scan_seq_regs.vh"
// Runs scans through the register port and checks order, pacing and results
module tb;
  reg clk_sys, rstn, reg_wr, reg_rd, reg_bcast, slow;
  reg [7:0] reg_addr;
  reg [15:0] reg_wdata, rd_val;
  wire [15:0] reg_rdata;
  wire trig_fwd, adc_start, adc_chop, adc_done, busy;
  wire [3:0] adc_chan;
  wire [11:0] adc_data;
  integer fails, tests_run, gap, fwd_n, k;
  // Start log {chop, chan}, cycles before each start, expected results 0x20..0x2E
  reg [4:0] conv_q[$];
  integer gap_q[$];
  reg [15:0] exp_reg[0:14];

  cell_scan_sequencer #(.OFFSET_TRIM(12'h000), .SETTLE_UNIT(16'd2)) u_cell_scan_sequencer (
    .clk_sys(clk_sys), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_bcast(reg_bcast),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .trig_fwd(trig_fwd),
    .adc_start(adc_start), .adc_chan(adc_chan), .adc_chop(adc_chop), .adc_done(adc_done),
    .adc_data(adc_data), .busy(busy));
  adc_model u_adc_model (.clk_sys(clk_sys), .rstn(rstn), .slow(slow), .adc_start(adc_start),
    .adc_chan(adc_chan), .adc_chop(adc_chop), .adc_done(adc_done), .adc_data(adc_data));

  // 100 MHz clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Logs starts with cycles since the last result or accepted trigger
  always @(posedge clk_sys)
  begin
    gap <= (adc_done || (reg_wr && reg_addr == `CONV_CTRL_ADDR && !busy)) ? 0 : gap + 1;
    fwd_n <= fwd_n + trig_fwd;
    if (adc_start)
    begin
      conv_q.push_back({adc_chop, adc_chan});
      gap_q.push_back(gap);
    end
  end

  task check(input string what, input [15:0] seen, input [15:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task stop_test;
  begin
    $display("Checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Write strobe held for one taking edge
  task wr(input [7:0] a, input [15:0] d, input b);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_bcast <= b;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  end
  endtask

  // Read; data taken a cycle after the strobe edge
  task rchk(input string what, input [7:0] a, input [15:0] exp);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rd_val = reg_rdata;
    check(what, rd_val, exp);
  end
  endtask

  // Program, trigger, retrigger while busy, then compare log and results
  task automatic run_scan(input [11:0] en, input [2:0] cfg, input [7:0] acq, input b);
    reg [4:0] exp_q[$];
    integer lo_q[$];
    integer c, p, f, n, fwd_base;
  begin
    wr(`CONV_CFG_ADDR, {13'h0000, cfg}, 1'b0);
    wr(`CELL_EN_ADDR, {4'h0, en}, 1'b0);
    wr(`ACQ_CFG_ADDR, {8'h00, acq}, 1'b0);
    rchk("enables", `CELL_EN_ADDR, {4'h0, en});
    conv_q = {};
    gap_q = {};
    fwd_base = fwd_n;
    wr(`CONV_CTRL_ADDR, 16'h0001, b);
    rchk("busy", `CONV_CTRL_ADDR, 16'h0002);
    wr(`CONV_CTRL_ADDR, 16'h0001, 1'b1);
    n = 0;
    while (busy !== 1'b0 && n < 30000)
    begin
      @(posedge clk_sys);
      n = n + 1;
    end
    if (n >= 30000)
    begin
      fails = fails + 1;
      stop_test;
    end
    for (p = 0; p < 2; p = p + 1)
    begin
      f = 1;
      for (c = 12; c >= 1; c = c - 1)
        if (en[c-1])
        begin
          exp_q.push_back({p[0], c[3:0]});
          lo_q.push_back(exp_q.size() == 1 ? 1695 : (f ? 566 : 382));
          f = 0;
          exp_reg[c-1] = {c[3:0], (slow ? 8'h51 : 8'h41), 4'h0};
        end
    end
    if (cfg[`CFG_DIAG_EN_BIT])
    begin
      exp_q.push_back({1'b0, `CHAN_DIAG});
      exp_q.push_back({1'b1, `CHAN_DIAG});
      lo_q.push_back(382);
      lo_q.push_back(382);
      exp_reg[14] = {`CHAN_DIAG, (slow ? 8'h51 : 8'h41), 4'h0};
    end
    for (c = 0; c < 2; c = c + 1)
      if (cfg[c])
      begin
        exp_q.push_back({1'b0, `CHAN_AUX_ONE + c[3:0]});
        lo_q.push_back(acq != 8'h00 ? 389 : 382);
        exp_reg[12 + c] = {`CHAN_AUX_ONE + c[3:0], (slow ? 8'h50 : 8'h40), 4'h0};
      end
    check("conversions", 16'(conv_q.size()), 16'(exp_q.size()));
    check("forwards", 16'(fwd_n - fwd_base), {15'h0000, b});
    for (c = 0; c < exp_q.size() && c < conv_q.size(); c = c + 1)
    begin
      check("order", {11'h000, conv_q[c]}, {11'h000, exp_q[c]});
      check("pacing", 16'(gap_q[c] >= lo_q[c] && gap_q[c] <= lo_q[c] + 6), 16'h0001);
    end
    for (c = 0; c < 15; c = c + 1)
      rchk("result", `CELL_DATA_BASE + c[7:0], exp_reg[c]);
  end
  endtask

  // Reset, reset values, then two scans of different shape
  initial
  begin
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_bcast = 1'b0;
    slow = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    fails = 0;
    tests_run = 0;
    gap = 0;
    fwd_n = 0;
    for (k = 0; k < 15; k = k + 1)
      exp_reg[k] = 16'h0000;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rchk("config", `CONV_CFG_ADDR, `CONV_CFG_RST);
    rchk("enables", `CELL_EN_ADDR, `CELL_EN_RST);
    rchk("settling", `ACQ_CFG_ADDR, `ACQ_CFG_RST);
    rchk("unmapped", 8'h05, 16'h0000);
    run_scan(12'hA05, 3'h7, 8'h03, 1'b1);
    slow <= 1'b1;
    run_scan(12'h801, 3'h1, 8'h00, 1'b0);
    stop_test;
  end
endmodule // tb
